/* rfbs_pkg.sv */
// Package of constants and types for the radio frame buffer sequencer.
// Function
// - Listening states detect frames, raise frame-start flag.
// - Finished frame reception raises the frame-done flag.
// - Early reads wait 32 us after frame-start.
// - Reads overtaking reception raise the underrun flag.
// - Buffer-empty indication paces early host reads.
// - Trigger pin or send command starts transmission.
// - Finished transmission raises the frame-done flag.
// - Transmission may start before buffer is written.
// - Device generates the synchronization header itself.
// - Settle one symbol, header 40/10 symbols, then PHR.
// - Slow host writes during sending raise underrun.
package rfbs_pkg;
  localparam int CLK_MHZ       = 25;
  localparam int SYM_US        = 16;
  localparam int SYM_CYC       = SYM_US * CLK_MHZ;
  localparam int RD_GAP_US     = 32;
  localparam int RD_GAP_CYC    = RD_GAP_US * CLK_MHZ;
  localparam int SETTLE_SYM    = 1;
  localparam int SHR_SYM_BPSK  = 40;
  localparam int SHR_SYM_OQPSK = 10;
  localparam int SHR_BYTES     = 5;
  localparam int FB_DEPTH      = 128;
  localparam logic [7:0] PRE_BYTE  = 8'h00;
  localparam logic [7:0] SFD_BYTE  = 8'hA7;
  localparam logic [7:0] CMD_FB_WR = 8'h60;
  localparam logic [7:0] CMD_FB_RD = 8'h20;
  localparam logic [3:0] BYTE_SYM_BPSK  = 4'h8;
  localparam logic [3:0] BYTE_SYM_OQPSK = 4'h2;
  localparam logic [4:0] SC_TX_START = 5'h02;
  localparam logic [4:0] SC_RX_ON    = 5'h06;
  localparam logic [4:0] SC_TRX_OFF  = 5'h08;
  localparam logic [4:0] SC_PLL_ON   = 5'h09;
  localparam logic [4:0] SC_RX_AACK  = 5'h16;
  localparam logic [4:0] SC_TX_ARET  = 5'h19;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_PLL_ON  = 3'b001,
    ST_RX_ON   = 3'b010,
    ST_RX_AACK = 3'b011,
    ST_TX_ARET = 3'b100,
    ST_BUSY_TX = 3'b101,
    ST_BUSY_RX = 3'b110
  } rfbs_state_t;
endpackage

/* rfbs_skid.sv */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
module rfbs_skid
  import rfbs_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Filling side.
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Draining side.
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic [1:0]        cnt;
    logic              rp;
    logic              wp;
  } rfbs_skid_t;

  rfbs_skid_t s_r;
  rfbs_skid_t s_nxt;
  logic       push;
  logic       pop;

  always_comb
  begin
    s_nxt = s_r;
    push  = in_valid && (s_r.cnt != 2'h2);
    pop   = out_ready && (s_r.cnt != 2'h0);
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp          = !s_r.wp;
    end
    if (pop)
    begin
      s_nxt.rp = !s_r.rp;
    end
    s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign in_ready  = (s_r.cnt != 2'h2);
  assign out_valid = (s_r.cnt != 2'h0);
  assign out_data  = s_r.mem[s_r.rp];
endmodule

/* rfbs_sequencer.sv */
// Frame buffer, host serial port and receive/transmit sequencing.
`timescale 1ns/100ps
module rfbs_sequencer
  import rfbs_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Host serial port.
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  // Host trigger pin.
  input  wire logic        tx_trigger_pin,
  // Control from the host side.
  input  wire logic [4:0]  state_command_field,
  input  wire logic        state_cmd_wr,
  input  wire logic        mod_bpsk,
  input  wire logic        rx_start_en,
  input  wire logic        irq_status_rd,
  // Status to the host side.
  output rfbs_state_t      transceiver_state_reg,
  output logic             frame_start_irq,
  output logic             frame_done_irq,
  output logic             buffer_underrun_irq,
  output logic             fb_empty,
  // Demodulator.
  input  wire logic        rx_sof,
  input  wire logic        rx_byte_vld,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_eof,
  // Modulator.
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready
);
  typedef struct packed {
    logic [2:0]                 sck_s;
    logic [2:0]                 cs_s;
    logic [2:0]                 mosi_s;
    logic [2:0]                 trg_s;
    logic                       sck_f;
    logic                       cs_f;
    logic                       mosi_f;
    logic                       trg_f;
    rfbs_state_t                st;
    rfbs_state_t                back;
    logic [FB_DEPTH-1:0][7:0]   fb;
    logic [7:0]                 wr_cnt;
    logic [2:0]                 bitc;
    logic [7:0]                 sh;
    logic [7:0]                 so;
    logic                       cmd_done;
    logic                       spi_rd;
    logic                       spi_wr;
    logic [7:0]                 spi_idx;
    logic                       miso;
    logic [9:0]                 gap;
    logic                       gap_ok;
    logic [8:0]                 sym_div;
    logic                       settled;
    logic [3:0]                 sc;
    logic [2:0]                 shr_cnt;
    logic [7:0]                 tx_idx;
    logic                       pend;
    logic [7:0]                 pend_b;
    logic                       f_start;
    logic                       f_done;
    logic                       f_ur;
    logic                       empty;
    logic                       ur_pend;
    logic                       oe;
  } rfbs_seq_t;

  rfbs_seq_t s_r;
  rfbs_seq_t s_nxt;
  logic      pend_rdy;

  function automatic logic filt(input logic [2:0] ch, input logic prev);
    filt = (ch[1] == ch[2]) ? ch[2] : prev;
  endfunction

  always_comb
  begin
    logic       set_start;
    logic       set_done;
    logic       set_ur;
    logic       sck_rise;
    logic       sck_fall;
    logic       trg_rise;
    logic       tick;
    logic       slot;
    logic       go_tx;
    logic [7:0] b;
    logic [7:0] rb;
    logic [3:0] bp;
    set_start = 1'b0;
    set_done  = 1'b0;
    set_ur    = 1'b0;
    tick      = 1'b0;
    slot      = 1'b0;
    go_tx     = 1'b0;
    b         = 8'h00;
    rb        = 8'h00;
    bp        = mod_bpsk ? BYTE_SYM_BPSK : BYTE_SYM_OQPSK;
    s_nxt     = s_r;
    s_nxt.sck_s  = {s_r.sck_s[1:0], spi_sclk};
    s_nxt.cs_s   = {s_r.cs_s[1:0], spi_cs_n};
    s_nxt.mosi_s = {s_r.mosi_s[1:0], spi_mosi};
    s_nxt.trg_s  = {s_r.trg_s[1:0], tx_trigger_pin};
    s_nxt.sck_f  = filt(s_r.sck_s, s_r.sck_f);
    s_nxt.cs_f   = filt(s_r.cs_s, s_r.cs_f);
    s_nxt.mosi_f = filt(s_r.mosi_s, s_r.mosi_f);
    s_nxt.trg_f  = filt(s_r.trg_s, s_r.trg_f);
    sck_rise = s_nxt.sck_f && !s_r.sck_f;
    sck_fall = !s_nxt.sck_f && s_r.sck_f;
    trg_rise = s_nxt.trg_f && !s_r.trg_f;

    // Early read gate after frame start.
    if (s_r.gap != RD_GAP_CYC[9:0])
    begin
      s_nxt.gap = s_r.gap + 10'h001;
    end
    else
    begin
      s_nxt.gap_ok = 1'b1;
    end

    // State commands and trigger pin.
    if (state_cmd_wr && s_r.st != ST_BUSY_TX && s_r.st != ST_BUSY_RX)
    begin
      case (state_command_field)
        SC_TX_START: go_tx = (s_r.st == ST_PLL_ON) || (s_r.st == ST_TX_ARET);
        SC_TRX_OFF:  s_nxt.st = ST_OFF;
        SC_PLL_ON:   s_nxt.st = ST_PLL_ON;
        SC_RX_ON:    s_nxt.st = ST_RX_ON;
        SC_RX_AACK:  s_nxt.st = ST_RX_AACK;
        SC_TX_ARET:  s_nxt.st = ST_TX_ARET;
        default:     s_nxt.st = s_r.st;
      endcase
    end
    if (trg_rise && (s_r.st == ST_PLL_ON || s_r.st == ST_TX_ARET))
    begin
      go_tx = 1'b1;
    end

    // Receive and transmit paths.
    case (s_r.st)
      ST_RX_ON, ST_RX_AACK:
      begin
        if (rx_sof)
        begin
          s_nxt.st     = ST_BUSY_RX;
          s_nxt.back   = s_r.st;
          s_nxt.wr_cnt = 8'h00;
          s_nxt.gap    = 10'h000;
          s_nxt.gap_ok = 1'b0;
          set_start    = rx_start_en;
        end
      end
      ST_BUSY_RX:
      begin
        if (rx_byte_vld && s_r.wr_cnt != FB_DEPTH[7:0])
        begin
          s_nxt.fb[s_r.wr_cnt[6:0]] = rx_byte;
          s_nxt.wr_cnt              = s_r.wr_cnt + 8'h01;
        end
        if (rx_eof)
        begin
          s_nxt.st = s_r.back;
          set_done = 1'b1;
        end
      end
      ST_BUSY_TX:
      begin
        if (!s_r.pend)
        begin
          if (s_r.sym_div == SYM_CYC[8:0] - 9'h001)
          begin
            s_nxt.sym_div = 9'h000;
            tick          = 1'b1;
          end
          else
          begin
            s_nxt.sym_div = s_r.sym_div + 9'h001;
          end
        end
        if (tick)
        begin
          if (!s_r.settled)
          begin
            s_nxt.settled = 1'b1;
            slot          = 1'b1;
          end
          else if (s_r.sc == bp - 4'h1)
          begin
            s_nxt.sc = 4'h0;
            slot     = 1'b1;
          end
          else
          begin
            s_nxt.sc = s_r.sc + 4'h1;
          end
        end
        if (slot)
        begin
          if (s_r.shr_cnt != SHR_BYTES[2:0])
          begin
            s_nxt.pend    = 1'b1;
            s_nxt.pend_b  = (s_r.shr_cnt == SHR_BYTES[2:0] - 3'h1) ? SFD_BYTE : PRE_BYTE;
            s_nxt.shr_cnt = s_r.shr_cnt + 3'h1;
          end
          else if (s_r.tx_idx >= s_r.wr_cnt)
          begin
            set_ur   = 1'b1;
            s_nxt.st = s_r.back;
          end
          else
          begin
            s_nxt.pend   = 1'b1;
            s_nxt.pend_b = s_r.fb[s_r.tx_idx[6:0]];
            s_nxt.tx_idx = s_r.tx_idx + 8'h01;
            if (s_r.tx_idx == {1'b0, s_r.fb[0][6:0]})
            begin
              s_nxt.st = s_r.back;
              set_done = 1'b1;
            end
          end
        end
      end
      default:
      begin
        s_nxt.st = s_nxt.st;
      end
    endcase
    if (go_tx)
    begin
      s_nxt.st      = ST_BUSY_TX;
      s_nxt.back    = s_r.st;
      s_nxt.sym_div = 9'h000;
      s_nxt.settled = 1'b0;
      s_nxt.sc      = 4'h0;
      s_nxt.shr_cnt = 3'h0;
      s_nxt.tx_idx  = 8'h00;
    end
    if (s_r.pend && pend_rdy)
    begin
      s_nxt.pend = 1'b0;
    end

    // Host serial port, clock idles low, data taken on the rising edge.
    if (s_r.cs_f)
    begin
      s_nxt.bitc     = 3'h0;
      s_nxt.cmd_done = 1'b0;
      s_nxt.spi_rd   = 1'b0;
      s_nxt.spi_wr   = 1'b0;
      s_nxt.ur_pend  = 1'b0;
    end
    else if (sck_rise)
    begin
      set_ur     = set_ur || (s_r.spi_rd && s_r.ur_pend && (s_r.bitc == 3'h0));
      b          = {s_r.sh[6:0], s_r.mosi_f};
      s_nxt.sh   = b;
      s_nxt.bitc = s_r.bitc + 3'h1;
      if (s_r.bitc == 3'h7)
      begin
        if (!s_r.cmd_done)
        begin
          s_nxt.cmd_done = 1'b1;
          s_nxt.spi_rd   = (b == CMD_FB_RD);
          s_nxt.spi_wr   = (b == CMD_FB_WR);
          s_nxt.spi_idx  = 8'h00;
        end
        else if (s_r.spi_wr && s_r.st != ST_BUSY_RX && s_r.spi_idx != FB_DEPTH[7:0])
        begin
          s_nxt.fb[s_r.spi_idx[6:0]] = b;
          s_nxt.wr_cnt               = s_r.spi_idx + 8'h01;
          s_nxt.spi_idx              = s_r.spi_idx + 8'h01;
        end
      end
    end
    else if (sck_fall && s_r.spi_rd)
    begin
      if (s_r.bitc == 3'h0)
      begin
        if (s_r.st == ST_BUSY_RX && (!s_r.gap_ok || s_r.spi_idx >= s_r.wr_cnt))
        begin
          s_nxt.ur_pend = 1'b1;
        end
        else
        begin
          s_nxt.ur_pend = 1'b0;
          rb            = s_r.fb[s_r.spi_idx[6:0]];
        end
        s_nxt.miso    = rb[7];
        s_nxt.so      = {rb[6:0], 1'b0};
        s_nxt.spi_idx = s_r.spi_idx + 8'h01;
      end
      else
      begin
        s_nxt.miso = s_r.so[7];
        s_nxt.so   = {s_r.so[6:0], 1'b0};
      end
    end

    s_nxt.oe      = !s_nxt.cs_f;
    s_nxt.empty   = (s_nxt.st == ST_BUSY_RX) && (s_nxt.spi_idx >= s_nxt.wr_cnt);
    s_nxt.f_start = set_start || (s_r.f_start && !irq_status_rd);
    s_nxt.f_done  = set_done || (s_r.f_done && !irq_status_rd);
    s_nxt.f_ur    = set_ur || (s_r.f_ur && !irq_status_rd);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s_r       <= '0;
      s_r.sck_s <= 3'h0;
      s_r.cs_s  <= 3'h7;
      s_r.cs_f  <= 1'b1;
      s_r.gap_ok <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  rfbs_skid #(
    .W (8)
  ) u_skid (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_data   (s_r.pend_b),
    .in_valid  (s_r.pend),
    .in_ready  (pend_rdy),
    .out_data  (tx_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );

  assign spi_miso              = s_r.miso;
  assign spi_miso_oe           = s_r.oe;
  assign transceiver_state_reg = s_r.st;
  assign frame_start_irq       = s_r.f_start;
  assign frame_done_irq        = s_r.f_done;
  assign buffer_underrun_irq   = s_r.f_ur;
  assign fb_empty              = s_r.empty;
endmodule

/* rfbs_sequencer_props.sv */
// Port assertions for the frame buffer sequencer.
`timescale 1ns/100ps
module rfbs_props
  import rfbs_pkg::*;
(
  // Clock, reset and controls.
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        tx_trigger_pin,
  input wire logic [4:0]  state_command_field,
  input wire logic        state_cmd_wr,
  input wire logic        rx_start_en,
  input wire logic        irq_status_rd,
  input wire logic        rx_sof,
  input wire logic        rx_eof,
  input wire logic        tx_ready,
  // Status and modulator.
  input wire rfbs_state_t transceiver_state_reg,
  input wire logic        frame_start_irq,
  input wire logic        frame_done_irq,
  input wire logic        buffer_underrun_irq,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid
);
  rfbs_state_t st;
  logic [9:0]  age_r;
  logic [9:0]  age_nxt;
  assign st = transceiver_state_reg;
  // Counts cycles spent sending, saturating at the top.
  always_comb age_nxt = (st == ST_BUSY_TX) ? age_r + {9'h000, ~&age_r} : 10'h000;
  always_ff @(posedge clk_sys) age_r <= rst_n ? age_nxt : 10'h000;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_sof;
    rx_sof && (st inside {ST_RX_ON, ST_RX_AACK});
  endsequence
  sequence s_ready;
    st inside {ST_PLL_ON, ST_TX_ARET};
  endsequence
  a_start_flag: assert property (s_sof ##0 rx_start_en |=>
    frame_start_irq && st == ST_BUSY_RX) else $error("start not flagged");
  a_rx_done: assert property (st == ST_BUSY_RX && rx_eof |=>
    frame_done_irq && st != ST_BUSY_RX) else $error("receive end not flagged");
  a_flag_clear: assert property ($fell(buffer_underrun_irq) |-> $past(irq_status_rd))
    else $error("flag lost");
  a_cmd_tx: assert property (s_ready ##0 state_cmd_wr && state_command_field == SC_TX_START
    |=> st == ST_BUSY_TX) else $error("send command ignored");
  a_pin_tx: assert property (s_ready ##0 $rose(tx_trigger_pin) |-> ##[1:6] st == ST_BUSY_TX)
    else $error("trigger pin ignored");
  a_tx_done: assert property ($fell(st == ST_BUSY_TX) |-> ##[0:1]
    (frame_done_irq || buffer_underrun_irq)) else $error("send end not flagged");
  a_shr_wait: assert property (tx_valid && st == ST_BUSY_TX |-> age_r >= 10'd398)
    else $error("byte before settling");
  a_stall_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("stalled byte lost");
endmodule
bind rfbs_sequencer rfbs_props u_rfbs_props (.*);

/* rfbs_host.sv */
// Host model: serial port master in mode 0, paced by the system clock.
`timescale 1ns/100ps
module rfbs_host
  import rfbs_pkg::*;
(
  // Clock and serial port.
  input  wire logic clk_sys,
  input  wire logic spi_miso,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi
);
  logic [7:0] rd_q[$];
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // Sends a command and the given bytes; returned bytes land in rd_q.
  task automatic xfer(input logic [7:0] c, input logic [7:0] w[$]);
    logic [7:0] b;
    rd_q = {};
    w.push_front(c);
    spi_cs_n = 1'b0;
    foreach (w[i])
    begin
      for (int k = 7; k >= 0; k--)
      begin
        spi_mosi = w[i][k];
        repeat (4) @(negedge clk_sys);
        spi_sclk = 1'b1;
        repeat (3) @(negedge clk_sys);
        b[k] = spi_miso;
        @(negedge clk_sys);
        spi_sclk = 1'b0;
      end
      if (i > 0) rd_q.push_back(b);
    end
    repeat (4) @(negedge clk_sys);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
  endtask
endmodule

/* rfbs_sequencer_bench.sv */
// Self-checking bench for the frame buffer sequencer.
`timescale 1ns/100ps
module rfbs_sequencer_bench
  import rfbs_pkg::*;
  ;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        tx_ready = 1'b1;
  logic        spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, fb_empty;
  logic        tx_trigger_pin, state_cmd_wr, mod_bpsk, rx_start_en, irq_status_rd;
  logic        rx_sof, rx_byte_vld, rx_eof, tx_valid;
  logic        frame_start_irq, frame_done_irq, buffer_underrun_irq;
  logic [4:0]  state_command_field;
  logic [7:0]  rx_byte, tx_data;
  logic [7:0]  got_q[$];
  logic [7:0]  rx_m[$];
  rfbs_state_t transceiver_state_reg, st;
  logic [4:0]  cmd_l[5] = '{SC_PLL_ON, SC_RX_ON, SC_RX_AACK, SC_TX_ARET, SC_TRX_OFF};
  rfbs_state_t st_l[5] = '{ST_PLL_ON, ST_RX_ON, ST_RX_AACK, ST_TX_ARET, ST_OFF};
  int          err_count = 0;
  int          checked = 0;
  int          cyc = 0;
  assign st = transceiver_state_reg;
  rfbs_sequencer u_rfbs_sequencer (.*);
  rfbs_host u_rfbs_host (.*);
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  // Modulator stand-in: stalls at random and collects bytes.
  always @(negedge clk_sys) tx_ready <= ($urandom % 4) != 0;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (tx_valid && tx_ready) got_q.push_back(tx_data);
    if (cyc == 90000)
    begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc_n(1);
    s = 1'b0;
    cyc_n(1);
  endtask
  task automatic cmd(input logic [4:0] c);
    state_command_field = c;
    pulse(state_cmd_wr);
  endtask
  task automatic rd_cmp();
    u_rfbs_host.xfer(CMD_FB_RD, rx_m);
    foreach (rx_m[i]) chk(u_rfbs_host.rd_q[i], rx_m[i]);
  endtask
  task automatic tx_run(input logic bpsk, input logic pin, input logic [4:0] home,
                        input rfbs_state_t hs, input int len, input int nw);
    logic [7:0] w[$];
    logic [7:0] e[$];
    mod_bpsk = bpsk;
    cmd(home);
    w = {8'(len)};
    repeat (len) w.push_back(8'($urandom));
    e = {PRE_BYTE, PRE_BYTE, PRE_BYTE, PRE_BYTE, SFD_BYTE, w[0:nw-1]};
    got_q = {};
    tx_trigger_pin = pin;
    if (!pin) cmd(SC_TX_START);
    cyc_n(8);
    tx_trigger_pin = 1'b0;
    chk(st, ST_BUSY_TX);
    u_rfbs_host.xfer(CMD_FB_WR, w[0:nw-1]);
    for (int t = 0; t < 40000 && st == ST_BUSY_TX; t++) cyc_n(1);
    cyc_n(10);
    chk(st, hs);
    chk({frame_done_irq, buffer_underrun_irq}, (nw > len) ? 8'h02 : 8'h01);
    chk(8'(got_q.size()), 8'(e.size()));
    foreach (e[i]) chk(got_q[i], e[i]);
    pulse(irq_status_rd);
    $display("test transmit done");
  endtask
  initial
  begin
    void'($urandom(72388));
    {tx_trigger_pin, state_cmd_wr, mod_bpsk, rx_start_en, irq_status_rd} = 5'h00;
    {rx_sof, rx_byte_vld, rx_eof, rx_byte, state_command_field} = 16'h0000;
    cyc_n(6);
    rst_n = 1'b1;
    cyc_n(4);
    chk({frame_start_irq, frame_done_irq, buffer_underrun_irq, fb_empty, tx_valid, spi_miso_oe},
        8'h00);
    cmd(SC_TX_START);
    chk(st, ST_OFF);
    foreach (cmd_l[i])
    begin
      cmd(cmd_l[i]);
      chk(st, st_l[i]);
    end
    $display("test commands done");
    cmd(SC_RX_AACK);
    rx_start_en = 1'b1;
    pulse(rx_sof);
    chk({st == ST_BUSY_RX, frame_start_irq}, 8'h03);
    u_rfbs_host.xfer(CMD_FB_RD, '{8'h00});
    chk(u_rfbs_host.rd_q[0], 8'h00);
    chk({frame_start_irq, buffer_underrun_irq}, 8'h03);
    pulse(irq_status_rd);
    repeat (6)
    begin
      rx_byte = 8'($urandom);
      rx_m.push_back(rx_byte);
      pulse(rx_byte_vld);
    end
    cyc_n(800);
    chk(fb_empty, 1'b0);
    rd_cmp();
    chk({fb_empty, buffer_underrun_irq}, 8'h02);
    pulse(rx_eof);
    chk({st == ST_RX_AACK, frame_done_irq}, 8'h03);
    rd_cmp();
    pulse(irq_status_rd);
    chk({frame_start_irq, frame_done_irq, buffer_underrun_irq}, 8'h00);
    cmd(SC_RX_ON);
    rx_start_en = 1'b0;
    pulse(rx_sof);
    chk({st == ST_BUSY_RX, frame_start_irq}, 8'h02);
    pulse(rx_eof);
    chk({st == ST_RX_ON, frame_done_irq}, 8'h03);
    pulse(irq_status_rd);
    $display("test receive done");
    tx_run(1'b1, 1'b1, SC_PLL_ON, ST_PLL_ON, 3, 4);
    tx_run(1'b0, 1'b0, SC_TX_ARET, ST_TX_ARET, 3, 4);
    tx_run(1'b0, 1'b1, SC_PLL_ON, ST_PLL_ON, 2, 1);
    end_of_test();
  end
endmodule
